/* common/i2c_exp_map.svh */
// Constants shared by both ends of the eight-output expander link.
// Assumes the core clock runs at the period given below.
`ifndef I2C_EXP_MAP_SVH
`define I2C_EXP_MAP_SVH

`define CLK_PERIOD_NS 40
// Standard-mode bus clock period made by the master end.
`define SCL_PERIOD_NS 10000
// Least quarter period of the bus clock, rounded up to whole cycles.
`define QUARTER_CYC ((`SCL_PERIOD_NS + 4 * `CLK_PERIOD_NS - 1) / (4 * `CLK_PERIOD_NS))
`define QCNT_W 7
`define ADDR_PREFIX 3'h5
`define BIT_ACK 4'h8
`define RW_READ 1'b1
`define FIFO_WIDTH 8
`define FIFO_DEPTH 32
`define INIT_DONE 2'h3

`endif

/* common/i2c_exp_pkg.sv */
// Types shared by both ends of the expander link.
// Assumes nothing of its surroundings.
package i2c_exp_pkg;

  typedef enum logic [2:0] {
    D_IDLE     = 3'h0,
    D_ADDR     = 3'h1,
    D_ADDR_ACK = 3'h3,
    D_WR_DATA  = 3'h2,
    D_WR_ACK   = 3'h6,
    D_RD_DATA  = 3'h7,
    D_RD_ACK   = 3'h5,
    D_IGNORE   = 3'h4
  } dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE  = 2'h0,
    H_START = 2'h1,
    H_BYTE  = 2'h3,
    H_STOP  = 2'h2
  } host_state_t;

  // How an address select pin is wired.
  typedef enum logic [1:0] {
    SEL_GND = 2'h0,
    SEL_VP  = 2'h1,
    SEL_SDA = 2'h2,
    SEL_SCL = 2'h3
  } sel_code_t;

endpackage

/* common/i2c_link_if.sv */
// Two-wire link between the master end and the expander end.
// Assumes a pull-up on SDA; SCL is driven only by the master.
interface i2c_link_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  wire  sda;

  // Open-drain wired-AND with a pull-up.
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);

  modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
  modport slave  (input scl, input sda, output s_sda_o, output s_sda_oe);
endinterface

/* hdl/byte_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`include "i2c_exp_map.svh"

module byte_fifo #(
  parameter int WIDTH = `FIFO_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  wire              push;
  wire              pop;

  assign in_ready  = (wr_ptr_reg - rd_ptr_reg) != (AW + 1)'(DEPTH);
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + (AW + 1)'(push);
      rd_ptr_reg <= rd_ptr_reg + (AW + 1)'(pop);
    end
  end
endmodule // byte_fifo

/* hdl/i2c_expander_dev.sv */
// Expander end: a two-wire slave driving eight push-pull outputs.
// Assumes SCL and SDA arrive through the link and are sampled by clk.
`include "i2c_exp_map.svh"

module i2c_expander_dev
  import i2c_exp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  i2c_link_if.slave       link,
  input  wire logic       addr_sel_low,
  input  wire logic       addr_sel_high,
  input  wire logic       bus_clear_n,
  input  wire logic [7:0] pin_levels,
  output logic      [7:0] output_pins
);
  // Every outside level passes two flip-flops before use.
  logic [1:0] scl_sy;
  logic [1:0] sda_sy;
  logic [1:0] low_sy;
  logic [1:0] high_sy;
  logic [1:0] clr_sy;
  logic [7:0] pin_sy0;
  logic [7:0] pin_sy1;
  logic       scl_d;
  logic       sda_d;
  logic       low_d;
  logic       high_d;

  dev_state_t state_reg;
  dev_state_t state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [7:0] sh_reg;
  logic [7:0] sh_next;
  logic [7:0] rd_reg;
  logic [7:0] rd_next;
  logic       oe_reg;
  logic       oe_next;
  logic       rw_reg;
  logic       rw_next;
  logic [7:0] out_reg;
  logic [7:0] out_next;
  sel_code_t  low_code_reg;
  sel_code_t  low_code_next;
  sel_code_t  high_code_reg;
  sel_code_t  high_code_next;
  logic       low_st_reg;
  logic       low_st_next;
  logic       high_st_reg;
  logic       high_st_next;
  logic [1:0] init_reg;

  wire scl_s = scl_sy[1];
  wire sda_s = sda_sy[1];
  wire rise  = scl_s & ~scl_d;
  wire fall  = ~scl_s & scl_d;
  wire start = scl_s & scl_d & sda_d & ~sda_s;
  wire stop  = scl_s & scl_d & ~sda_d & sda_s;
  wire clear = ~clr_sy[1];
  wire init  = init_reg == `INIT_DONE - 2'h1;
  wire last  = cnt_reg == `BIT_ACK;

  // A pin strapped to a line follows it: at start SCL is high and SDA
  // low, and before the first rise SCL is low and SDA high. A master
  // sending a zero first bit blurs the SDA case, but then no expander
  // address can match anyway.
  function automatic sel_code_t sel_decode(input logic at_start, input logic before_rise);
    case ({at_start, before_rise})
      2'h0:    sel_decode = SEL_GND;
      2'h3:    sel_decode = SEL_VP;
      2'h1:    sel_decode = SEL_SDA;
      default: sel_decode = SEL_SCL;
    endcase
  endfunction

  function automatic logic [1:0] high_bits(input sel_code_t c);
    case (c)
      SEL_SCL: high_bits = 2'h0;
      SEL_SDA: high_bits = 2'h1;
      SEL_GND: high_bits = 2'h2;
      default: high_bits = 2'h3;
    endcase
  endfunction

  function automatic logic [1:0] low_bits(input sel_code_t c);
    case (c)
      SEL_GND: low_bits = 2'h0;
      SEL_VP:  low_bits = 2'h1;
      SEL_SCL: low_bits = 2'h2;
      default: low_bits = 2'h3;
    endcase
  endfunction

  wire [6:0] my_addr = {`ADDR_PREFIX, high_bits(high_code_reg), low_bits(low_code_reg)};
  wire       match   = sh_reg[7:1] == my_addr;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scl_sy  <= 2'h3;
      sda_sy  <= 2'h3;
      low_sy  <= 2'h0;
      high_sy <= 2'h0;
      clr_sy  <= 2'h3;
      pin_sy0 <= 8'h00;
      pin_sy1 <= 8'h00;
    end else begin
      scl_sy  <= {scl_sy[0], link.scl};
      sda_sy  <= {sda_sy[0], link.sda};
      low_sy  <= {low_sy[0], addr_sel_low};
      high_sy <= {high_sy[0], addr_sel_high};
      clr_sy  <= {clr_sy[0], bus_clear_n};
      pin_sy0 <= pin_levels;
      pin_sy1 <= pin_sy0;
    end
  end

  always_comb begin
    state_next     = state_reg;
    cnt_next       = cnt_reg;
    sh_next        = sh_reg;
    rd_next        = rd_reg;
    oe_next        = oe_reg;
    rw_next        = rw_reg;
    out_next       = out_reg;
    low_code_next  = low_code_reg;
    high_code_next = high_code_reg;
    low_st_next    = low_st_reg;
    high_st_next   = high_st_reg;
    if (init) begin
      // Strapped lines read high at power-up, so they select high too.
      out_next       = {{4{high_sy[1]}}, {4{low_sy[1]}}};
      low_code_next  = low_sy[1] ? SEL_VP : SEL_GND;
      high_code_next = high_sy[1] ? SEL_VP : SEL_GND;
    end
    if (clear) begin
      state_next = D_IDLE;
      oe_next    = 1'b0;
    end else if (start) begin
      state_next   = D_ADDR;
      cnt_next     = 4'h0;
      oe_next      = 1'b0;
      low_st_next  = low_sy[1];
      high_st_next = high_sy[1];
    end else if (stop) begin
      state_next = D_IDLE;
      oe_next    = 1'b0;
    end else begin
      case (state_reg)
        D_ADDR: begin
          if (rise) begin
            sh_next  = {sh_reg[6:0], sda_s};
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == 4'h0) begin
              low_code_next  = sel_decode(low_st_reg, low_d);
              high_code_next = sel_decode(high_st_reg, high_d);
            end
          end else if (fall && last) begin
            rw_next = sh_reg[0];
            if (match) begin
              state_next = D_ADDR_ACK;
              oe_next    = 1'b1;
            end else begin
              state_next = D_IGNORE;
            end
          end
        end
        D_ADDR_ACK: begin
          if (rise) begin
            rd_next = pin_sy1;
          end else if (fall) begin
            cnt_next = 4'h0;
            if (rw_reg == `RW_READ) begin
              state_next = D_RD_DATA;
              oe_next    = ~rd_reg[7];
              rd_next    = {rd_reg[6:0], 1'b0};
            end else begin
              state_next = D_WR_DATA;
              oe_next    = 1'b0;
            end
          end
        end
        D_WR_DATA: begin
          if (rise) begin
            sh_next  = {sh_reg[6:0], sda_s};
            cnt_next = cnt_reg + 4'h1;
          end else if (fall && last) begin
            out_next   = sh_reg;
            oe_next    = 1'b1;
            state_next = D_WR_ACK;
          end
        end
        D_WR_ACK: begin
          if (fall) begin
            oe_next    = 1'b0;
            cnt_next   = 4'h0;
            state_next = D_WR_DATA;
          end
        end
        D_RD_DATA: begin
          if (rise) begin
            cnt_next = cnt_reg + 4'h1;
          end else if (fall) begin
            if (cnt_reg == `BIT_ACK) begin
              oe_next    = 1'b0;
              state_next = D_RD_ACK;
            end else begin
              oe_next = ~rd_reg[7];
              rd_next = {rd_reg[6:0], 1'b0};
            end
          end
        end
        D_RD_ACK: begin
          if (rise) begin
            rd_next = pin_sy1;
            if (sda_s) begin
              state_next = D_IGNORE;
            end
          end else if (fall) begin
            cnt_next   = 4'h0;
            state_next = D_RD_DATA;
            oe_next    = ~rd_reg[7];
            rd_next    = {rd_reg[6:0], 1'b0};
          end
        end
        default: begin
          oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
      low_d    <= 1'b0;
      high_d   <= 1'b0;
      init_reg <= 2'h0;
    end else begin
      scl_d    <= scl_s;
      sda_d    <= sda_s;
      low_d    <= low_sy[1];
      high_d   <= high_sy[1];
      init_reg <= init_reg == `INIT_DONE ? init_reg : init_reg + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg     <= D_IDLE;
      cnt_reg       <= 4'h0;
      sh_reg        <= 8'h00;
      rd_reg        <= 8'h00;
      oe_reg        <= 1'b0;
      rw_reg        <= 1'b0;
      out_reg       <= 8'h00;
      low_code_reg  <= SEL_GND;
      high_code_reg <= SEL_GND;
      low_st_reg    <= 1'b0;
      high_st_reg   <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      sh_reg        <= sh_next;
      rd_reg        <= rd_next;
      oe_reg        <= oe_next;
      rw_reg        <= rw_next;
      out_reg       <= out_next;
      low_code_reg  <= low_code_next;
      high_code_reg <= high_code_next;
      low_st_reg    <= low_st_next;
      high_st_reg   <= high_st_next;
    end
  end

  assign output_pins   = out_reg;
  assign link.s_sda_o  = 1'b0;
  assign link.s_sda_oe = oe_reg;
endmodule // i2c_expander_dev

/* hdl/i2c_master_end.sv */
// Master end: makes SCL by dividing clk and runs one transfer per command.
// Assumes a single slave answers; write bytes are queued in a FIFO.
`include "i2c_exp_map.svh"

module i2c_master_end
  import i2c_exp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  i2c_link_if.master      link,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic [6:0] cmd_addr,
  input  wire logic       cmd_read,
  input  wire logic [7:0] cmd_len,
  input  wire logic       wr_valid,
  output logic            wr_ready,
  input  wire logic [7:0] wr_data,
  output logic            rd_valid,
  output logic      [7:0] rd_data,
  output logic            done,
  output logic            nack
);
  host_state_t        state_reg;
  logic [`QCNT_W-1:0] qcnt_reg;
  logic [1:0]         phase_reg;
  logic [3:0]         bit_reg;
  logic [7:0]         tx_reg;
  logic [7:0]         rx_reg;
  logic [7:0]         len_reg;
  logic               rd_reg;
  logic               first_reg;
  logic               scl_reg;
  logic               oe_reg;
  logic [1:0]         sda_sy;
  logic               rdv_reg;
  logic [7:0]         rdata_reg;
  logic               done_reg;
  logic               nack_reg;
  logic               q_valid;
  logic [7:0]         q_data;

  wire tick     = qcnt_reg == `QCNT_W'(`QUARTER_CYC - 1);
  wire ack_end  = state_reg == H_BYTE && phase_reg == 2'h3 && bit_reg == `BIT_ACK;
  wire ackd     = ~sda_sy[1];
  wire more     = first_reg ? len_reg != 8'h00 : len_reg != 8'h01;
  wire go_on    = more && (rd_reg && !first_reg || ackd);
  wire need_wr  = go_on && !rd_reg;
  // Holding SCL high while the queue is empty stalls the bus, not the data.
  wire hold     = ack_end && need_wr && !q_valid;
  wire advance  = tick && !hold;
  wire pop      = advance && ack_end && need_wr;
  wire drive_rx = rd_reg && !first_reg;

  byte_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (q_valid),
    .out_ready (pop),
    .out_data  (q_data)
  );

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sda_sy   <= 2'h3;
      qcnt_reg <= '0;
    end else begin
      sda_sy   <= {sda_sy[0], link.sda};
      qcnt_reg <= (tick || state_reg == H_IDLE) ? (hold ? qcnt_reg : '0) : qcnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= H_IDLE;
      phase_reg <= 2'h0;
      bit_reg   <= 4'h0;
      tx_reg    <= 8'h00;
      rx_reg    <= 8'h00;
      len_reg   <= 8'h00;
      rd_reg    <= 1'b0;
      first_reg <= 1'b0;
      scl_reg   <= 1'b1;
      oe_reg    <= 1'b0;
      rdv_reg   <= 1'b0;
      rdata_reg <= 8'h00;
      done_reg  <= 1'b0;
      nack_reg  <= 1'b0;
    end else begin
      rdv_reg  <= 1'b0;
      done_reg <= 1'b0;
      case (state_reg)
        H_IDLE: begin
          if (cmd_valid) begin
            state_reg <= H_START;
            oe_reg    <= 1'b1;
            phase_reg <= 2'h0;
            tx_reg    <= {cmd_addr, cmd_read};
            len_reg   <= cmd_len;
            rd_reg    <= cmd_read;
            first_reg <= 1'b1;
            nack_reg  <= 1'b0;
          end
        end
        H_START: begin
          if (advance) begin
            phase_reg <= phase_reg + 2'h1;
            if (phase_reg == 2'h1) begin
              scl_reg   <= 1'b0;
              state_reg <= H_BYTE;
              phase_reg <= 2'h0;
              bit_reg   <= 4'h0;
            end
          end
        end
        H_BYTE: begin
          if (advance) begin
            phase_reg <= phase_reg + 2'h1;
            case (phase_reg)
              2'h0: begin
                // SDA changes only while SCL is low.
                if (bit_reg == `BIT_ACK) begin
                  oe_reg <= drive_rx && len_reg != 8'h01;
                end else begin
                  oe_reg <= !drive_rx && !tx_reg[7];
                end
              end
              2'h1: scl_reg <= 1'b1;
              2'h3: begin
                scl_reg <= 1'b0;
                if (bit_reg != `BIT_ACK) begin
                  rx_reg  <= {rx_reg[6:0], sda_sy[1]};
                  tx_reg  <= {tx_reg[6:0], 1'b0};
                  bit_reg <= bit_reg + 4'h1;
                end else begin
                  first_reg <= 1'b0;
                  bit_reg   <= 4'h0;
                  if (!first_reg) begin
                    len_reg <= len_reg - 8'h01;
                  end
                  if (drive_rx) begin
                    rdv_reg   <= 1'b1;
                    rdata_reg <= rx_reg;
                  end
                  if (!ackd && !drive_rx) begin
                    nack_reg <= 1'b1;
                  end
                  if (go_on) begin
                    tx_reg <= q_data;
                  end else begin
                    state_reg <= H_STOP;
                  end
                end
              end
              default: begin
              end
            endcase
          end
        end
        default: begin
          if (advance) begin
            phase_reg <= phase_reg + 2'h1;
            case (phase_reg)
              2'h0: oe_reg <= 1'b1;
              2'h1: scl_reg <= 1'b1;
              2'h3: begin
                oe_reg    <= 1'b0;
                state_reg <= H_IDLE;
                done_reg  <= 1'b1;
              end
              default: begin
              end
            endcase
          end
        end
      endcase
    end
  end

  assign cmd_ready     = state_reg == H_IDLE;
  assign link.scl      = scl_reg;
  assign link.m_sda_o  = 1'b0;
  assign link.m_sda_oe = oe_reg;
  assign rd_valid      = rdv_reg;
  assign rd_data       = rdata_reg;
  assign done          = done_reg;
  assign nack          = nack_reg;
endmodule // i2c_master_end

/* testbench/i2c_eight_output_expander_tb_top.sv */
// Bench joining the master end and the expander end through the link carrier.
// Assumes the package, the carrier and both ends are compiled before it.
module i2c_eight_output_expander_tb_top
  import i2c_exp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       bus_clear_n = 1'b1;
  logic       cmd_valid = 1'b0;
  logic       cmd_read = 1'b0;
  logic       wr_valid = 1'b0;
  logic       mon_on = 1'b0;
  logic [6:0] cmd_addr = 7'h00;
  logic [7:0] cmd_len = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic [7:0] force_mask = 8'h00;
  logic [7:0] cur = 8'h00;
  logic [7:0] last_out;
  sel_code_t  sel_hi = SEL_VP;
  sel_code_t  sel_lo = SEL_GND;
  logic       cmd_ready;
  logic       wr_ready;
  logic       rd_valid;
  logic       done;
  logic       nack;
  logic       addr_sel_low;
  logic       addr_sel_high;
  logic [7:0] rd_data;
  logic [7:0] output_pins;
  int         error_cnt = 0;
  int         total_checks = 0;
  int         rd_n = 0;
  logic [7:0] wq[$];
  logic [7:0] rq[$];
  logic [7:0] mq[$];

  i2c_link_if link ();

  function automatic logic pin_of(sel_code_t c, logic sda, logic scl);
    return c == SEL_GND ? 1'b0 : c == SEL_VP ? 1'b1 : c == SEL_SDA ? sda : scl;
  endfunction

  function automatic logic [6:0] addr_of(sel_code_t h, sel_code_t l);
    return {3'h5, h == SEL_GND || h == SEL_VP, h == SEL_SDA || h == SEL_VP,
            l == SEL_SCL || l == SEL_SDA, l == SEL_VP || l == SEL_SDA};
  endfunction

  assign addr_sel_low  = pin_of(sel_lo, link.sda, link.scl);
  assign addr_sel_high = pin_of(sel_hi, link.sda, link.scl);

  always #20 clk = ~clk;

  i2c_master_end i_i2c_master_end (.clk(clk), .reset_n(reset_n), .link(link.master),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_addr(cmd_addr), .cmd_read(cmd_read),
    .cmd_len(cmd_len), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack(nack));
  i2c_expander_dev i_i2c_expander_dev (.clk(clk), .reset_n(reset_n), .link(link.slave),
    .addr_sel_low(addr_sel_low), .addr_sel_high(addr_sel_high), .bus_clear_n(bus_clear_n),
    .pin_levels(output_pins ^ force_mask), .output_pins(output_pins));
  i2c_link_sva i_i2c_link_sva (.clk(clk), .reset_n(reset_n), .scl(link.scl), .sda(link.sda),
    .m_sda_o(link.m_sda_o), .m_sda_oe(link.m_sda_oe), .s_sda_o(link.s_sda_o),
    .s_sda_oe(link.s_sda_oe));

  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic do_reset(sel_code_t h, sel_code_t l);
    @(negedge clk);
    sel_hi = h;
    sel_lo = l;
    reset_n = 1'b0;
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask

  task automatic push(logic [7:0] b);
    @(negedge clk);
    wr_valid = 1'b1;
    wr_data = b;
    @(posedge clk);
    while (wr_ready !== 1'b1) @(posedge clk);
    wq.push_back(b);
    cur = b;
    @(negedge clk);
    wr_valid = 1'b0;
  endtask

  task automatic run(logic [6:0] a, logic rd, logic [7:0] n, logic exp_nack);
    @(negedge clk);
    cmd_addr = a;
    cmd_read = rd;
    cmd_len = n;
    cmd_valid = 1'b1;
    @(posedge clk);
    while (cmd_ready !== 1'b1) @(posedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    while (done !== 1'b1) @(negedge clk);
    check("nack", {7'h00, exp_nack}, {7'h00, nack});
  endtask

  // Every change of the outputs must be the next byte written, so a stray update shows.
  always @(negedge clk) begin
    if (rd_valid === 1'b1) begin
      rd_n++;
      check("read byte", rq.size() ? rq.pop_front() : 8'h00, rd_data);
      if (mq.size()) force_mask = mq.pop_front();
    end
    if (mon_on && output_pins !== last_out) begin
      check("outputs", wq.size() ? wq.pop_front() : last_out, output_pins);
      last_out = output_pins;
    end
  end

  initial begin
    void'($urandom(22139));
    for (int h = 0; h < 4; h++) begin
      for (int l = 0; l < 4; l++) begin
        do_reset(sel_code_t'(h), sel_code_t'(l));
        check("power-up", {{4{sel_hi != SEL_GND}}, {4{sel_lo != SEL_GND}}}, output_pins);
      end
    end
    last_out = output_pins;
    mon_on = 1'b1;
    sel_hi = SEL_VP;
    sel_lo = SEL_GND;
    run(addr_of(SEL_VP, SEL_VP), 1'b0, 8'h00, 1'b1);
    run(7'h6C, 1'b0, 8'h00, 1'b1);
    fork
      run(addr_of(SEL_VP, SEL_GND), 1'b0, 8'h00, 1'b1);
      begin
        repeat (900) @(negedge clk);
        bus_clear_n = 1'b0;
        repeat (4) @(negedge clk);
        bus_clear_n = 1'b1;
      end
    join
    for (int i = 0; i < 32; i++) push({3'($urandom), 5'(i)});
    @(negedge clk);
    check("fifo ready", 8'h00, {7'h00, wr_ready});
    run(addr_of(SEL_VP, SEL_GND), 1'b0, 8'h1D, 1'b0);
    sel_hi = SEL_SDA;
    sel_lo = SEL_SCL;
    run(addr_of(SEL_SDA, SEL_SCL), 1'b0, 8'h01, 1'b0);
    run(addr_of(SEL_VP, SEL_GND), 1'b0, 8'h00, 1'b1);
    sel_hi = SEL_SCL;
    sel_lo = SEL_SDA;
    run(addr_of(SEL_SCL, SEL_SDA), 1'b0, 8'h02, 1'b0);
    check("writes left", 8'h00, 8'(wq.size()));
    // Each byte is sampled one acknowledge ahead of its read strobe.
    mq = {8'h3C, 8'hA5};
    force_mask = 8'h81;
    rq = {cur ^ 8'h81, cur ^ 8'h81, cur ^ 8'h3C};
    run(addr_of(SEL_SCL, SEL_SDA), 1'b1, 8'h03, 1'b0);
    check("read count", 8'h03, 8'(rd_n));
    conclude();
  end

  // The planned traffic needs about 100000 cycles; the limit leaves some slack above it.
  initial begin
    repeat (120000) @(posedge clk);
    error_cnt++;
    conclude();
  end
endmodule // i2c_eight_output_expander_tb_top

/* testbench/i2c_link_sva.sv */
// Concurrent checks on the two-wire link between the master end and the expander end.
// Assumes the link signals arrive as plain inputs, sampled by clk with a synchronous reset.
module i2c_link_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       scl_reg;
  logic       sda_reg;
  logic       busy_reg;
  logic       rw_reg;
  logic       quiet_reg;
  logic [3:0] bit_reg;
  logic [1:0] byte_reg;
  logic [2:0] top_reg;
  wire        start_det = scl && scl_reg && sda_reg && !sda;
  wire        stop_det  = scl && scl_reg && !sda_reg && sda;
  wire        scl_rise  = scl && !scl_reg;
  wire        last_bit  = bit_reg == 4'h8;
  wire        addr_byte = byte_reg == 2'h0;

  always_ff @(posedge clk) begin
    scl_reg <= reset_n ? scl : 1'b1;
    sda_reg <= reset_n ? sda : 1'b1;
  end

  // The stop condition itself follows one extra clock rise, so bit_reg reads 1 there.
  always_ff @(posedge clk) begin
    if (!reset_n || start_det) begin
      busy_reg  <= reset_n;
      bit_reg   <= 4'h0;
      byte_reg  <= 2'h0;
      quiet_reg <= 1'b0;
    end else if (stop_det) begin
      busy_reg <= 1'b0;
    end else if (scl_rise) begin
      bit_reg   <= last_bit ? 4'h0 : bit_reg + 4'h1;
      byte_reg  <= (last_bit && byte_reg != 2'h2) ? byte_reg + 2'h1 : byte_reg;
      quiet_reg <= quiet_reg || (last_bit && sda && (addr_byte || rw_reg));
    end
  end

  always_ff @(posedge clk) begin
    if (scl_rise && addr_byte && bit_reg < 4'h3) top_reg <= {top_reg[1:0], sda};
    if (scl_rise && addr_byte && bit_reg == 4'h7) rw_reg <= sda;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  dev_pull_a: assert property (s_sda_oe |-> !s_sda_o)
    else $error("expander drives sda high");
  host_pull_a: assert property (m_sda_oe |-> !m_sda_o)
    else $error("master drives sda high");
  start_hold_a: assert property (start_det |-> scl [*8])
    else $error("clock fell too soon after start");
  first_fall_a: assert property ($fell(scl) |-> busy_reg)
    else $error("clock fell on an idle bus");
  bit_hold_a: assert property (scl_rise |-> ##124 scl)
    else $error("clock high phase too short");
  oe_steady_a: assert property (scl && scl_reg |-> $stable(s_sda_oe))
    else $error("expander changed sda while clock high");
  addr_ack_a: assert property (scl_rise && last_bit && addr_byte && s_sda_oe |-> top_reg == 3'h5)
    else $error("address acknowledged with wrong top bits");
  wr_ack_a: assert property (scl_rise && last_bit && !addr_byte && !rw_reg && !quiet_reg |-> s_sda_oe)
    else $error("written byte not acknowledged");
  wr_free_a: assert property (scl_rise && !addr_byte && !rw_reg && !last_bit |-> !s_sda_oe)
    else $error("expander drives sda during write data");
  rd_ack_a: assert property (scl_rise && last_bit && !addr_byte && rw_reg |-> !s_sda_oe)
    else $error("expander drives the read acknowledge");
  rd_owner_a: assert property (scl_rise && !quiet_reg && !addr_byte && rw_reg && !last_bit |-> !m_sda_oe)
    else $error("master drives sda during read data");
  quiet_a: assert property (quiet_reg |-> !s_sda_oe)
    else $error("expander drives sda after being refused");
  idle_a: assert property (!busy_reg |-> !s_sda_oe)
    else $error("expander drives sda on a free bus");
  stop_a: assert property (stop_det |-> bit_reg == 4'h1)
    else $error("stop inside a byte");
endmodule // i2c_link_sva
